// ==== logic/led_sink_pkg.sv ====
// shared constants and types of the serial-in led sink latch
// assumes a single core clock; all pins arrive asynchronous to it
package led_sink_pkg;

   // ****************************************************************
   // sizes and reset values
   // ****************************************************************
   localparam int          CHAN_COUNT     = 16;
   localparam logic [15:0] WORD_RESET     = 16'h0000;
   localparam logic        SERIAL_RESET   = 1'b0;
   // a driven sink pin is pulled low; enable low means driving
   localparam logic        SINK_LEVEL     = 1'b0;
   localparam logic        SINK_RELEASED  = 1'b1;
   localparam logic        GATE_OFF_N     = 1'b1;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int          CORE_PERIOD_PS = 4000;
   localparam int          SYNC_STAGES    = 2;

   // ****************************************************************
   // pin group
   // ****************************************************************
   typedef struct packed {
      logic shift_clk;
      logic serial_bit_in;
      logic latch_strobe;
      logic out_gate_n;
   } pin_in_t;

   localparam int          PIN_COUNT      = $bits(pin_in_t);
   localparam logic [3:0]  PIN_RESET      = 4'h1;

endpackage

// ==== logic/pin_sync.sv ====
// two-flop synchroniser with rising-edge detect, one lane per bit
// assumes inputs asynchronous to core_clk_i; rst_i synchronous
`timescale 1ns/100ps
`default_nettype none
module pin_sync
#(
   parameter int               WIDTH     = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output var  logic [WIDTH-1:0] level_o,
   output var  logic [WIDTH-1:0] rise_o
);

   // ****************************************************************
   // per-bit lanes
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : lane
         logic meta_reg;
         logic meta_next;
         logic sync_reg;
         logic sync_next;
         logic prev_reg;
         logic prev_next;

         always_comb
         begin
            meta_next = async_i[g];
            sync_next = meta_reg;
            prev_next = sync_reg;
         end

         // edge detect reads only the second stage and its delayed copy, never the first
         always_ff @(posedge core_clk_i)
         begin
            if (rst_i)
            begin
               meta_reg <= RESET_VAL[g];
               sync_reg <= RESET_VAL[g];
               prev_reg <= RESET_VAL[g];
            end
            else
            begin
               meta_reg <= meta_next;
               sync_reg <= sync_next;
               prev_reg <= prev_next;
            end
         end

         assign level_o[g] = sync_reg;
         assign rise_o[g]  = sync_reg & ~prev_reg;
      end
   endgenerate

endmodule
`default_nettype wire

// ==== logic/led_sink_latch.sv ====
// serial-in parallel-out latch and gate logic of a 16-channel led sink
// assumes shift clock, data, strobe and gate pins are asynchronous to
// core_clk_i, with the shift clock well below a quarter of its rate
//
// How it works
// (RULE_01) a 16-bit shift register feeds a parallel latch word
// (RULE_02) sixteen channels, each steered by one latched bit
// (RULE_03) each shift clock rising edge samples the serial input into the register
// (RULE_04) latch strobe high copies the shift register into the latch
// (RULE_05) gate low switches on every channel whose latched bit is one
// (RULE_06) an active channel pulls its pin low; inactive ones release it
// (RULE_07) last stage drives the serial output; latch holds while strobe low
`timescale 1ns/100ps
`default_nettype none
module led_sink_latch
#(
   parameter int CHAN = led_sink_pkg::CHAN_COUNT
)
(
   input  wire logic            core_clk_i,
   input  wire logic            rst_i,
   input  wire logic            shift_clk_i,
   input  wire logic            serial_bit_in_i,
   input  wire logic            latch_strobe_i,
   input  wire logic            out_gate_n_i,
   output var  logic            serial_bit_out_o,
   output var  logic [CHAN-1:0] sink_channel_o,
   output var  logic [CHAN-1:0] sink_channel_oe_n_o,
   output var  logic [CHAN-1:0] latched_word_o
);

   // ****************************************************************
   // pin synchronisation
   // ****************************************************************
   led_sink_pkg::pin_in_t pins_async;
   led_sink_pkg::pin_in_t pins_level;
   led_sink_pkg::pin_in_t pins_rise;

   always_comb
   begin
      pins_async.shift_clk     = shift_clk_i;
      pins_async.serial_bit_in = serial_bit_in_i;
      pins_async.latch_strobe  = latch_strobe_i;
      pins_async.out_gate_n    = out_gate_n_i;
   end

   // all pins see the same latency, so data stays aligned with its clock
   pin_sync
   #(
      .WIDTH     (led_sink_pkg::PIN_COUNT),
      .RESET_VAL (led_sink_pkg::PIN_RESET)
   )
   u_pin_sync
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .async_i    (pins_async),
      .level_o    (pins_level),
      .rise_o     (pins_rise)
   );

   // ****************************************************************
   // shift register and latch
   // ****************************************************************
   logic [CHAN-1:0] shift_reg;
   logic [CHAN-1:0] shift_next;
   logic [CHAN-1:0] latch_reg;
   logic [CHAN-1:0] latch_next;
   logic            serial_out_reg;
   logic            serial_out_next;

   always_comb
   begin
      shift_next = shift_reg;
      // (RULE_03) sample on clock rise
      if (pins_rise.shift_clk)
      begin
         // (RULE_01) newest bit enters stage zero
         shift_next = {shift_reg[CHAN-2:0], pins_level.serial_bit_in};
      end
      latch_next = latch_reg;
      // (RULE_04) transparent copy while strobe high
      if (pins_level.latch_strobe)
      begin
         latch_next = shift_next;
      end
      // (RULE_07) cascade bit from last stage
      serial_out_next = shift_next[CHAN-1];
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         shift_reg      <= CHAN'(led_sink_pkg::WORD_RESET);
         latch_reg      <= CHAN'(led_sink_pkg::WORD_RESET);
         serial_out_reg <= led_sink_pkg::SERIAL_RESET;
      end
      else
      begin
         shift_reg      <= shift_next;
         // (RULE_07) latch holds while strobe low
         latch_reg      <= latch_next;
         serial_out_reg <= serial_out_next;
      end
   end

   // ****************************************************************
   // output gate and sink drivers
   // ****************************************************************
   logic [CHAN-1:0] drive_en_n_reg;
   logic [CHAN-1:0] drive_en_n_next;

   genvar ch;
   generate
      for (ch = 0; ch < CHAN; ch = ch + 1)
      begin : chan
         always_comb
         begin
            // (RULE_05) gate low enables set bits
            // (RULE_02) one latched bit per channel
            if (!pins_level.out_gate_n && latch_next[ch])
            begin
               drive_en_n_next[ch] = ~led_sink_pkg::SINK_RELEASED;
            end
            else
            begin
               drive_en_n_next[ch] = led_sink_pkg::SINK_RELEASED;
            end
         end
      end
   endgenerate

   // released after reset so no led flashes at power-up
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         drive_en_n_reg <= {CHAN{led_sink_pkg::SINK_RELEASED}};
      end
      else
      begin
         drive_en_n_reg <= drive_en_n_next;
      end
   end

   // (RULE_06) sink by pulling pin low
   assign sink_channel_o      = {CHAN{led_sink_pkg::SINK_LEVEL}};
   assign sink_channel_oe_n_o = drive_en_n_reg;
   assign serial_bit_out_o    = serial_out_reg;
   assign latched_word_o      = latch_reg;

endmodule
`default_nettype wire

// ==== dv/led_sink_checker.sv ====
// port checker of the led sink latch
// assumes it is bound onto led_sink_latch
`timescale 1ns/100ps
`default_nettype none
module led_sink_checker
#(
   parameter int CHAN = 16
)
(
   input wire logic            core_clk_i,
   input wire logic            rst_i,
   input wire logic            shift_clk_i,
   input wire logic            serial_bit_in_i,
   input wire logic            latch_strobe_i,
   input wire logic            out_gate_n_i,
   input wire logic            serial_bit_out_o,
   input wire logic [CHAN-1:0] sink_channel_o,
   input wire logic [CHAN-1:0] sink_channel_oe_n_o,
   input wire logic [CHAN-1:0] latched_word_o
);
   // ****
   // properties; pins pass two sync flops, so counts carry slack
   // ****
   default clocking dc @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   a_shift_word_in: assert property (
      latch_strobe_i[*5] ##1 ($rose(shift_clk_i) && latch_strobe_i) ##1 latch_strobe_i[*6] |->
      latched_word_o == {$past(latched_word_o[CHAN-2:0], 6), $past(serial_bit_in_i, 6)})
      else $error("shift did not move the word by one bit");
   a_latch_follow: assert property ((latch_strobe_i && $stable(shift_clk_i))[*5] |=>
      latched_word_o[CHAN-1] == serial_bit_out_o) else $error("latch not copying the shift register");
   a_latch_hold: assert property ((!latch_strobe_i)[*4] |=> $stable(latched_word_o))
      else $error("latch changed while strobe low");
   a_out_cause: assert property ($changed(serial_bit_out_o) |-> $past(shift_clk_i, 3))
      else $error("serial out moved without a shift");
   a_gate_off: assert property (out_gate_n_i[*4] |=> &sink_channel_oe_n_o)
      else $error("channel on while gate high");
   a_gate_on: assert property ((!out_gate_n_i)[*4] |=> sink_channel_oe_n_o == ~latched_word_o)
      else $error("channels not following latch");
   a_sink_pull: assert property (sink_channel_o == '0)
      else $error("sink pin not pulled low");
endmodule
bind led_sink_latch led_sink_checker #(.CHAN(CHAN)) u_led_sink_checker (.core_clk_i, .rst_i, .shift_clk_i,
   .serial_bit_in_i, .latch_strobe_i, .out_gate_n_i, .serial_bit_out_o, .sink_channel_o,
   .sink_channel_oe_n_o, .latched_word_o);
`default_nettype wire

// ==== dv/led_sink_host.sv ====
// host controller model driving the serial chain
// assumes the bench calls its tasks; core_clk_i paces the pins
`timescale 1ns/100ps
`default_nettype none
module led_sink_host
(
   input  wire logic core_clk_i,
   output var  logic shift_clk_o,
   output var  logic serial_bit_o,
   output var  logic latch_strobe_o,
   output var  logic out_gate_n_o
);
   // ****
   // pin drivers; shift clock idles low between frames
   // ****
   initial
   begin
      shift_clk_o = 1'b0;
      serial_bit_o = 1'b0;
      latch_strobe_o = 1'b0;
      out_gate_n_o = 1'b1;
   end
   task automatic shift_bit(input logic b);
      @(posedge core_clk_i);
      serial_bit_o <= b;
      shift_clk_o <= 1'b1;
      repeat (20) @(posedge core_clk_i);
      shift_clk_o <= 1'b0;
      // hold over: stale data is inverted so it cannot pass by luck
      serial_bit_o <= ~b;
      repeat (20) @(posedge core_clk_i);
   endtask
   task automatic set_pins(input logic strobe, input logic gate_n);
      @(posedge core_clk_i);
      latch_strobe_o <= strobe;
      out_gate_n_o <= gate_n;
      repeat (8) @(posedge core_clk_i);
   endtask
endmodule
`default_nettype wire

// ==== dv/led_sink_latch_bench.sv ====
// self-checking bench of the led sink latch
// assumes the host model drives all pins
`timescale 1ns/100ps
`default_nettype none
module led_sink_latch_bench;
   localparam int CHAN = led_sink_pkg::CHAN_COUNT;
   logic            core_clk = 1'b0;
   logic            rst = 1'b1;
   wire logic       sclk, sdat, strobe, gate_n, sout;
   wire logic [CHAN-1:0] sink, sink_oe_n, latched;
   int              errors = 0;
   int              total_checks = 0;
   always #2 core_clk = ~core_clk;
   led_sink_host u_led_sink_host (.core_clk_i(core_clk), .shift_clk_o(sclk), .serial_bit_o(sdat),
      .latch_strobe_o(strobe), .out_gate_n_o(gate_n));
   led_sink_latch u_led_sink_latch (.core_clk_i(core_clk), .rst_i(rst), .shift_clk_i(sclk),
      .serial_bit_in_i(sdat), .latch_strobe_i(strobe), .out_gate_n_i(gate_n), .serial_bit_out_o(sout),
      .sink_channel_o(sink), .sink_channel_oe_n_o(sink_oe_n), .latched_word_o(latched));
   // ****
   // checks and scenarios
   // ****
   task automatic check(input logic [CHAN-1:0] got, input logic [CHAN-1:0] exp);
      #1;
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic scen_load_show();
      for (int i = CHAN - 1; i >= 0; i--)
         u_led_sink_host.shift_bit(1'(16'ha539 >> i));
      check(latched, 16'h0000);
      u_led_sink_host.set_pins(1'b1, 1'b1);
      u_led_sink_host.set_pins(1'b0, 1'b1);
      check(latched, 16'ha539);
      check(sink_oe_n, 16'hffff);
      u_led_sink_host.set_pins(1'b0, 1'b0);
      check(sink_oe_n, 16'h5ac6);
      check(sink, 16'h0000);
   endtask
   task automatic scen_cascade();
      logic [2*CHAN-1:0] c;
      c = {16'ha539, 16'h3c0f};
      // old word leaves bit by bit, first in first out
      for (int j = 1; j <= CHAN; j++)
      begin
         u_led_sink_host.shift_bit(c[CHAN-j]);
         check({15'h0000, sout}, {15'h0000, c[2*CHAN-1-j]});
      end
      u_led_sink_host.set_pins(1'b1, 1'b0);
      check(latched, 16'h3c0f);
      u_led_sink_host.shift_bit(1'b1);
      u_led_sink_host.shift_bit(1'b0);
      check(latched, 16'hf03e);
      check(sink_oe_n, 16'h0fc1);
      u_led_sink_host.set_pins(1'b0, 1'b0);
      u_led_sink_host.shift_bit(1'b1);
      check(latched, 16'hf03e);
   endtask
   initial
   begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      check(sink_oe_n, 16'hffff);
      scen_load_show();
      scen_cascade();
      tally_and_finish();
   end
   initial
   begin
      repeat (5000) @(posedge core_clk);
      errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
